// file: asg_map.svh
`ifndef ASG_MAP_SVH
`define ASG_MAP_SVH
// Behaviour
// R1 - chip reset pin low resets all channels and management logic
// R2 - reset pin held low at least 10 us after power is stable
// R3 - management data pin floats while chip reset pin is low
// R4 - management interface keeps serving writes and reads during software power down
// R5 - status bits may be meaningless while their clock is stopped
// R6 - management pin floats in pin power down, drives in register power down
// R7 - station manager supplies management clock for management frames
// R8 - aux clock pin defaults to output low, serial clock or general pin
// R9 - aux clock pin governed by field 15.14:12
// R10 - aux clock and outgoing data pins driven low during chip reset
// R11 - incoming data pin defaults to input, serial data in, field 15.10:8
// R12 - incoming data pin undriven in chip reset and pin power down
// R13 - outgoing data pin defaults to output low, serial data out, field 15.6:4
// R14 - select pin defaults output high, low selects, field 15.2:0
// R15 - select pin driven high during chip reset
// R16 - aux pins float in pin power down, follow fields in register power down
// R17 - software avoids driving a pin an external driver also drives
// R18 - answer frame only when upper address bits match strap; low bit picks channel
// R19 - field picks serial function, input, or output level; input level readable

// register bus word indexes
`define ASG_IDX_PD_A 3'h0
`define ASG_IDX_PD_B 3'h1
`define ASG_IDX_AUX 3'h2
`define ASG_IDX_STAT 3'h3
`define ASG_IDX_SPI 3'h4
// management register addresses and bits
`define ASG_MREG_PD 5'h01
`define ASG_MREG_AUX 5'h0f
`define ASG_PD_BIT 15
`define ASG_AUX_MASK 16'h7777
`define ASG_AUX_RST 16'h2123
`define ASG_FIELD_TOP 12
`define ASG_FIELD_STRIDE 4
`define ASG_STAT_BUSY 15
// pin indexes and reset drive
`define ASG_PIN_CLK 0
`define ASG_PIN_IN 1
`define ASG_PIN_OUT 2
`define ASG_PIN_SEL 3
`define ASG_RST_LVL 4'h8
`define ASG_RST_OE 4'hd
// field codes
`define ASG_FN_SPI 3'h0
`define ASG_FN_IN 3'h1
`define ASG_FN_LOW 3'h2
`define ASG_FN_HIGH 3'h3
// management frame
`define ASG_OP_RD 2'h2
`define ASG_OP_WR 2'h1
`define ASG_HDR_LAST 5'h0c
`define ASG_DATA_LAST 5'h0f
`define ASG_RD_DONE 5'h10
`define ASG_SKIP_LAST 5'h11
// serial master timing
`define ASG_SPI_HALF 4'h4
`define ASG_SPI_BITS 3'h7
`endif

// file: asg_pkg.sv
package asg_pkg;
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_HDR = 3'b001,
    MD_TA = 3'b010,
    MD_RDATA = 3'b011,
    MD_WTA = 3'b100,
    MD_WDATA = 3'b101,
    MD_SKIP = 3'b110
  } asg_mdio_state_type;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_LOW = 2'b01,
    SP_HIGH = 2'b10
  } asg_spi_state_type;
endpackage : asg_pkg

// file: asg_sync.sv
`timescale 1ns/1ns
module asg_sync #(
  parameter int W = 1
) (
  input wire logic CLK_I,
  input wire logic CE_I,
  input wire logic [W-1:0] D_I,
  output logic [W-1:0] Q_O
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  always_ff @(posedge CLK_I) begin
    if (CE_I) begin
      s1_r <= D_I;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes only once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge CLK_I) begin
      if (CE_I && (s2_r[i] == s3_r[i])) begin
        q_r[i] <= s3_r[i];
      end
    end
  end

  assign Q_O = q_r;
endmodule : asg_sync

// file: asg_pin_ctrl.sv
`timescale 1ns/1ns
`include "asg_map.svh"
module asg_pin_ctrl (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic CHIP_RESET_N_I,
  input wire logic LANE_A_POWERDOWN_LOW_I,
  input wire logic LANE_B_POWERDOWN_LOW_I,
  input wire logic [4:0] PORT_ADDRESS_STRAP_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic MDC_I,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_O,
  input wire logic AUX_CLK_I,
  output logic AUX_CLK_O,
  output logic AUX_CLK_OE_O,
  input wire logic AUX_INCOMING_DATA_PIN_I,
  output logic AUX_INCOMING_DATA_PIN_O,
  output logic AUX_INCOMING_DATA_PIN_OE_O,
  input wire logic AUX_OUTGOING_DATA_PIN_I,
  output logic AUX_OUTGOING_DATA_PIN_O,
  output logic AUX_OUTGOING_DATA_PIN_OE_O,
  input wire logic AUX_SELECT_I,
  output logic AUX_SELECT_O,
  output logic AUX_SELECT_OE_O
);
  import asg_pkg::*;

  // ---------------- system clock domain ----------------
  logic chip_rst_n_s;
  logic rst;
  logic pin_pd;
  logic [3:0] pad_in;
  logic [3:0] pin_lvl;
  logic [3:0] pin_o_r;
  logic [3:0] pin_oe_r;
  logic [3:0] spi_val;
  logic [3:0] spi_oe;
  logic [3:0] pad_o;
  logic [3:0] pad_oe;
  logic [1:0] pd_r;
  logic [15:0] aux_r;
  logic [15:0] rdata_r;
  asg_spi_state_type spi_st_r;
  logic [3:0] spi_div_r;
  logic [2:0] spi_bit_r;
  logic [7:0] spi_tx_r;
  logic [7:0] spi_rx_r;
  logic spi_clk_r;
  logic spi_mosi_r;
  logic spi_cs_r;
  logic spi_start;
  logic wr_tog_s;
  logic wr_seen_r;
  logic mdio_wr;
  logic mir_ack_s;
  logic mir_tog_r;
  logic [13:0] mir_data_r;

  // ---------------- management clock domain ----------------
  logic mdc_rst_n_s;
  logic [4:0] strap_r;
  asg_mdio_state_type md_st_r;
  logic [4:0] md_cnt_r;
  logic [11:0] md_hdr_r;
  logic [15:0] md_sh_r;
  logic md_o_r;
  logic md_oe_r;
  logic md_chan_r;
  logic [4:0] md_reg_r;
  logic [15:0] wr_data_r;
  logic wr_chan_r;
  logic [4:0] wr_reg_r;
  logic wr_tog_r;
  logic mir_tog_s;
  logic mir_ack_r;
  logic [13:0] mir_m_r;
  logic [12:0] md_full;
  logic md_match;
  logic [15:0] md_rword;

  asg_sync #(.W(1)) u_rst_sync (
    .CLK_I(CLK_SYS_I),
    .CE_I(CE_I),
    .D_I(CHIP_RESET_N_I),
    .Q_O(chip_rst_n_s)
  );

  asg_sync #(.W(4)) u_pad_sync (
    .CLK_I(CLK_SYS_I),
    .CE_I(CE_I),
    .D_I(pad_in),
    .Q_O(pin_lvl)
  );

  asg_sync #(.W(1)) u_wr_sync (
    .CLK_I(CLK_SYS_I),
    .CE_I(CE_I),
    .D_I(wr_tog_r),
    .Q_O(wr_tog_s)
  );

  asg_sync #(.W(1)) u_ack_sync (
    .CLK_I(CLK_SYS_I),
    .CE_I(CE_I),
    .D_I(mir_ack_r),
    .Q_O(mir_ack_s)
  );

  asg_sync #(.W(1)) u_mdc_rst_sync (
    .CLK_I(MDC_I),
    .CE_I(1'b1),
    .D_I(CHIP_RESET_N_I),
    .Q_O(mdc_rst_n_s)
  );

  asg_sync #(.W(1)) u_mir_sync (
    .CLK_I(MDC_I),
    .CE_I(1'b1),
    .D_I(mir_tog_r),
    .Q_O(mir_tog_s)
  );

  assign rst = SYS_RST_I | ~chip_rst_n_s; // R1
  assign pin_pd = ~LANE_A_POWERDOWN_LOW_I & ~LANE_B_POWERDOWN_LOW_I;
  assign pad_in = {AUX_SELECT_I, AUX_OUTGOING_DATA_PIN_I, AUX_INCOMING_DATA_PIN_I, AUX_CLK_I};
  assign mdio_wr = wr_tog_s != wr_seen_r;
  assign spi_start = REG_WE_I && (REG_ADDR_I == `ASG_IDX_SPI) && (spi_st_r == SP_IDLE);

  // control registers, written by the bus and by management frames
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      pd_r <= 2'h0;
      aux_r <= `ASG_AUX_RST; // R8 R11 R13 R14
      wr_seen_r <= wr_tog_s;
    end else if (CE_I) begin
      if (mdio_wr) begin
        wr_seen_r <= wr_tog_s;
        if (wr_reg_r == `ASG_MREG_PD) begin
          pd_r[wr_chan_r] <= wr_data_r[`ASG_PD_BIT]; // R4
        end else if (wr_reg_r == `ASG_MREG_AUX) begin
          aux_r <= wr_data_r & `ASG_AUX_MASK; // R4
        end
      end
      if (REG_WE_I) begin
        unique case (REG_ADDR_I)
          `ASG_IDX_PD_A: pd_r[0] <= REG_WDATA_I[`ASG_PD_BIT];
          `ASG_IDX_PD_B: pd_r[1] <= REG_WDATA_I[`ASG_PD_BIT];
          `ASG_IDX_AUX: aux_r <= REG_WDATA_I & `ASG_AUX_MASK; // R9
          default: ;
        endcase
      end
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      rdata_r <= 16'h0;
    end else if (CE_I) begin
      rdata_r <= 16'h0;
      if (REG_RE_I) begin
        unique case (REG_ADDR_I)
          `ASG_IDX_PD_A: rdata_r[`ASG_PD_BIT] <= pd_r[0];
          `ASG_IDX_PD_B: rdata_r[`ASG_PD_BIT] <= pd_r[1];
          `ASG_IDX_AUX: rdata_r <= aux_r;
          `ASG_IDX_STAT: rdata_r <= {spi_st_r != SP_IDLE, 11'h0, pin_lvl}; // R19 R5
          `ASG_IDX_SPI: rdata_r <= {8'h0, spi_rx_r};
          default: rdata_r <= 16'h0;
        endcase
      end
    end
  end

  assign REG_RDATA_O = rdata_r;

  // serial master, mode 0, one byte per write
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      spi_st_r <= SP_IDLE;
      spi_div_r <= 4'h0;
      spi_bit_r <= 3'h0;
      spi_tx_r <= 8'h0;
      spi_rx_r <= 8'h0;
      spi_clk_r <= 1'b0;
      spi_mosi_r <= 1'b0;
      spi_cs_r <= 1'b1;
    end else if (CE_I) begin
      unique case (spi_st_r)
        SP_IDLE: begin
          if (spi_start) begin
            spi_tx_r <= REG_WDATA_I[7:0];
            spi_mosi_r <= REG_WDATA_I[7];
            spi_bit_r <= `ASG_SPI_BITS;
            spi_div_r <= 4'h0;
            spi_cs_r <= 1'b0;
            spi_st_r <= SP_LOW;
          end
        end
        SP_LOW: begin
          spi_div_r <= spi_div_r + 4'h1;
          if (spi_div_r == `ASG_SPI_HALF - 4'h1) begin
            spi_div_r <= 4'h0;
            spi_clk_r <= 1'b1;
            spi_st_r <= SP_HIGH;
          end
        end
        SP_HIGH: begin
          spi_div_r <= spi_div_r + 4'h1;
          if (spi_div_r == `ASG_SPI_HALF - 4'h1) begin
            spi_div_r <= 4'h0;
            spi_clk_r <= 1'b0;
            // late in the high phase so the synced pad level has settled
            spi_rx_r <= {spi_rx_r[6:0], pin_lvl[`ASG_PIN_IN]};
            if (spi_bit_r == 3'h0) begin
              spi_cs_r <= 1'b1;
              spi_st_r <= SP_IDLE;
            end else begin
              spi_bit_r <= spi_bit_r - 3'h1;
              spi_tx_r <= {spi_tx_r[6:0], 1'b0};
              spi_mosi_r <= spi_tx_r[6];
              spi_st_r <= SP_LOW;
            end
          end
        end
        default: spi_st_r <= SP_IDLE;
      endcase
    end
  end

  assign spi_val = {spi_cs_r, spi_mosi_r, 1'b0, spi_clk_r};
  assign spi_oe = 4'hd;

  // per-pin function from its three-bit field
  genvar p;
  for (p = 0; p < 4; p++) begin : g_pin
    logic [2:0] fn;
    assign fn = aux_r[`ASG_FIELD_TOP - `ASG_FIELD_STRIDE * p +: 3];
    always_ff @(posedge CLK_SYS_I) begin
      if (rst) begin
        pin_o_r[p] <= 1'(`ASG_RST_LVL >> p);
        pin_oe_r[p] <= 1'(`ASG_RST_OE >> p);
      end else if (CE_I) begin
        unique case (fn)
          `ASG_FN_SPI: begin
            pin_o_r[p] <= spi_val[p]; // R19
            pin_oe_r[p] <= spi_oe[p];
          end
          `ASG_FN_LOW, `ASG_FN_HIGH: begin
            pin_o_r[p] <= fn[0]; // R19
            pin_oe_r[p] <= 1'b1;
          end
          default: begin
            pin_o_r[p] <= 1'b0;
            pin_oe_r[p] <= 1'b0;
          end
        endcase
      end
    end
    // register power down leaves the pins on their fields
    assign pad_o[p] = CHIP_RESET_N_I ? pin_o_r[p] : 1'(`ASG_RST_LVL >> p); // R10 R15
    assign pad_oe[p] = pin_pd ? 1'b0 : // R16 R12
      (CHIP_RESET_N_I ? pin_oe_r[p] : 1'(`ASG_RST_OE >> p)); // R10 R12 R15
  end

  assign AUX_CLK_O = pad_o[`ASG_PIN_CLK];
  assign AUX_CLK_OE_O = pad_oe[`ASG_PIN_CLK];
  assign AUX_INCOMING_DATA_PIN_O = pad_o[`ASG_PIN_IN];
  assign AUX_INCOMING_DATA_PIN_OE_O = pad_oe[`ASG_PIN_IN];
  assign AUX_OUTGOING_DATA_PIN_O = pad_o[`ASG_PIN_OUT];
  assign AUX_OUTGOING_DATA_PIN_OE_O = pad_oe[`ASG_PIN_OUT];
  assign AUX_SELECT_O = pad_o[`ASG_PIN_SEL];
  assign AUX_SELECT_OE_O = pad_oe[`ASG_PIN_SEL];

  // snapshot of control state handed to the management side
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      mir_tog_r <= mir_ack_s;
      mir_data_r <= 14'h0;
    end else if (CE_I && (mir_tog_r == mir_ack_s)) begin
      mir_data_r <= {pd_r, aux_r[14:12], aux_r[10:8], aux_r[6:4], aux_r[2:0]};
      mir_tog_r <= ~mir_tog_r;
    end
  end

  // ---------------- management frame logic on MDC ----------------
  assign md_full = {md_hdr_r, MDIO_I};
  assign md_match = md_full[12] && (md_full[9:6] == strap_r[4:1]); // R18

  always_comb begin
    md_rword = 16'h0;
    if (md_full[4:0] == `ASG_MREG_PD) begin
      md_rword[`ASG_PD_BIT] = mir_m_r[12 + md_full[5]];
    end else if (md_full[4:0] == `ASG_MREG_AUX) begin
      md_rword = {1'b0, mir_m_r[11:9], 1'b0, mir_m_r[8:6], 1'b0, mir_m_r[5:3],
                  1'b0, mir_m_r[2:0]};
    end
  end

  always_ff @(posedge MDC_I) begin
    if (!mdc_rst_n_s) begin
      mir_ack_r <= mir_tog_s;
      mir_m_r <= 14'h0;
    end else if (mir_tog_s != mir_ack_r) begin
      mir_m_r <= mir_data_r;
      mir_ack_r <= mir_tog_s;
    end
  end

  // strap caught while the reset is held
  always_ff @(posedge MDC_I) begin
    if (!mdc_rst_n_s) begin
      strap_r <= PORT_ADDRESS_STRAP_I; // R18
    end
  end

  always_ff @(posedge MDC_I) begin // R7
    if (!mdc_rst_n_s) begin
      md_st_r <= MD_IDLE;
      md_cnt_r <= 5'h0;
      md_hdr_r <= 12'h0;
      md_sh_r <= 16'h0;
      md_o_r <= 1'b0;
      md_oe_r <= 1'b0;
      md_chan_r <= 1'b0;
      md_reg_r <= 5'h0;
      wr_data_r <= 16'h0;
      wr_chan_r <= 1'b0;
      wr_reg_r <= 5'h0;
      wr_tog_r <= 1'b0;
    end else begin
      unique case (md_st_r)
        MD_IDLE: begin
          md_oe_r <= 1'b0;
          if (!MDIO_I) begin
            md_cnt_r <= 5'h0;
            md_st_r <= MD_HDR;
          end
        end
        MD_HDR: begin
          md_hdr_r <= md_full[11:0];
          md_cnt_r <= md_cnt_r + 5'h1;
          if (md_cnt_r == `ASG_HDR_LAST) begin
            md_cnt_r <= 5'h0;
            md_chan_r <= md_full[5]; // R18
            md_reg_r <= md_full[4:0];
            md_sh_r <= md_rword;
            if (md_match && md_full[11:10] == `ASG_OP_RD) begin
              md_st_r <= MD_TA;
            end else if (md_match && md_full[11:10] == `ASG_OP_WR) begin
              md_st_r <= MD_WTA;
            end else begin
              md_st_r <= MD_SKIP;
            end
          end
        end
        MD_TA: begin
          md_o_r <= 1'b0;
          md_oe_r <= 1'b1;
          md_st_r <= MD_RDATA;
        end
        MD_RDATA: begin
          md_cnt_r <= md_cnt_r + 5'h1;
          md_o_r <= md_sh_r[15];
          md_sh_r <= {md_sh_r[14:0], 1'b0};
          if (md_cnt_r == `ASG_RD_DONE) begin
            md_oe_r <= 1'b0;
            md_st_r <= MD_IDLE;
          end
        end
        MD_WTA: begin
          md_cnt_r <= md_cnt_r + 5'h1;
          if (md_cnt_r == 5'h1) begin
            md_cnt_r <= 5'h0;
            md_st_r <= MD_WDATA;
          end
        end
        MD_WDATA: begin
          md_cnt_r <= md_cnt_r + 5'h1;
          md_sh_r <= {md_sh_r[14:0], MDIO_I};
          if (md_cnt_r == `ASG_DATA_LAST) begin
            wr_data_r <= {md_sh_r[14:0], MDIO_I};
            wr_chan_r <= md_chan_r;
            wr_reg_r <= md_reg_r;
            wr_tog_r <= ~wr_tog_r;
            md_st_r <= MD_IDLE;
          end
        end
        MD_SKIP: begin
          md_cnt_r <= md_cnt_r + 5'h1;
          if (md_cnt_r == `ASG_SKIP_LAST) begin
            md_st_r <= MD_IDLE;
          end
        end
        default: md_st_r <= MD_IDLE;
      endcase
    end
  end

  assign MDIO_O = md_o_r;
  assign MDIO_OE_O = md_oe_r & CHIP_RESET_N_I & ~pin_pd; // R3 R6
endmodule : asg_pin_ctrl

// file: asg_pin_ctrl_sva.sv
`timescale 1ns/1ns
module asg_pin_ctrl_sva (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic CHIP_RESET_N_I,
  input wire logic LANE_A_POWERDOWN_LOW_I,
  input wire logic LANE_B_POWERDOWN_LOW_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic MDIO_OE_O,
  input wire logic AUX_CLK_O,
  input wire logic AUX_CLK_OE_O,
  input wire logic AUX_INCOMING_DATA_PIN_OE_O,
  input wire logic AUX_OUTGOING_DATA_PIN_O,
  input wire logic AUX_OUTGOING_DATA_PIN_OE_O,
  input wire logic AUX_SELECT_O,
  input wire logic AUX_SELECT_OE_O
);
  logic pin_pd;
  logic aux_wr;
  assign pin_pd = !LANE_A_POWERDOWN_LOW_I && !LANE_B_POWERDOWN_LOW_I;
  assign aux_wr = REG_WE_I && REG_ADDR_I == 3'h2 && CHIP_RESET_N_I && !pin_pd;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);
  a_rst_mdio_float: assert property (!CHIP_RESET_N_I |-> !MDIO_OE_O)
    else $error("mdio driven in reset");
  a_rst_clk_low: assert property (!CHIP_RESET_N_I |-> AUX_CLK_OE_O && !AUX_CLK_O)
    else $error("clk pin not low in reset");
  a_rst_out_low: assert property (!CHIP_RESET_N_I |->
      AUX_OUTGOING_DATA_PIN_OE_O && !AUX_OUTGOING_DATA_PIN_O) else $error("out pin not low");
  a_rst_sel_high: assert property (!CHIP_RESET_N_I |->
      AUX_SELECT_OE_O && AUX_SELECT_O) else $error("select not high in reset");
  a_rst_in_float: assert property (!CHIP_RESET_N_I |-> !AUX_INCOMING_DATA_PIN_OE_O)
    else $error("in pin driven in reset");
  a_pd_all_float: assert property (pin_pd |-> !(MDIO_OE_O || AUX_CLK_OE_O ||
      AUX_INCOMING_DATA_PIN_OE_O || AUX_OUTGOING_DATA_PIN_OE_O || AUX_SELECT_OE_O))
    else $error("pin driven in pin power down");
  a_clk_field_low: assert property (aux_wr && REG_WDATA_I[14:12] == 3'h2 |->
      ##[1:2] (AUX_CLK_OE_O && !AUX_CLK_O)) else $error("clk field low not applied");
  a_sel_field_high: assert property (aux_wr && REG_WDATA_I[2:0] == 3'h3 |->
      ##[1:2] (AUX_SELECT_OE_O && AUX_SELECT_O)) else $error("select field not applied");
  c_spi_select: cover property (AUX_SELECT_OE_O && !AUX_SELECT_O);
  c_pin_pd: cover property (pin_pd);
  c_chip_rst: cover property (!CHIP_RESET_N_I);
endmodule : asg_pin_ctrl_sva

bind asg_pin_ctrl asg_pin_ctrl_sva asg_pin_ctrl_sva_inst (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .CHIP_RESET_N_I(CHIP_RESET_N_I),
  .LANE_A_POWERDOWN_LOW_I(LANE_A_POWERDOWN_LOW_I),
  .LANE_B_POWERDOWN_LOW_I(LANE_B_POWERDOWN_LOW_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WE_I(REG_WE_I),
  .MDIO_OE_O(MDIO_OE_O), .AUX_CLK_O(AUX_CLK_O), .AUX_CLK_OE_O(AUX_CLK_OE_O),
  .AUX_INCOMING_DATA_PIN_OE_O(AUX_INCOMING_DATA_PIN_OE_O),
  .AUX_OUTGOING_DATA_PIN_O(AUX_OUTGOING_DATA_PIN_O),
  .AUX_OUTGOING_DATA_PIN_OE_O(AUX_OUTGOING_DATA_PIN_OE_O),
  .AUX_SELECT_O(AUX_SELECT_O), .AUX_SELECT_OE_O(AUX_SELECT_OE_O)
);

// file: asg_spi_partner.sv
`timescale 1ns/1ns
module asg_spi_partner (
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh_r;
  // drives only while selected
  assign miso_oe_o = !sel_n_i;
  assign miso_o = sh_r[7];
  always @(negedge sel_n_i) sh_r = tx_i;
  always @(negedge sclk_i) begin
    if (!sel_n_i) sh_r = {sh_r[6:0], 1'b0};
  end
  always @(posedge sclk_i) begin
    if (!sel_n_i) rx_o = {rx_o[6:0], mosi_i};
  end
endmodule : asg_spi_partner

// file: tb_asg_pin_ctrl.sv
`timescale 1ns/1ns
`include "asg_map.svh"
module tb_asg_pin_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chip_n = 1'b0;
  logic [1:0] lane_n = 2'b11;
  logic [2:0] addr = 3'h0;
  logic [15:0] wd = 16'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic mdc = 1'b0;
  logic m_o = 1'b1;
  logic m_oe = 1'b0;
  logic tog = 1'b0;
  logic s;
  logic [3:0] eoe = 4'h0;
  logic [3:0] elv = 4'h0;
  logic [15:0] v;
  wire [15:0] rdat;
  wire mdo, mdoe, mdio_w, p_o, p_oe;
  wire [3:0] doe, dout, eoe_w, elv_w, pin_w;
  wire [7:0] p_rx;
  int fail_count = 0;
  int checks = 0;
  int n;
  always #5 clk = ~clk;
  // undriven pins show a changing level
  always @(posedge clk) tog <= ~tog;
  assign mdio_w = mdoe ? mdo : (m_oe ? m_o : 1'b1);
  assign eoe_w = eoe | {2'b00, p_oe, 1'b0};
  assign elv_w = {elv[3:2], p_oe ? p_o : elv[1], elv[0]};
  assign pin_w = (doe & dout) | (~doe & eoe_w & elv_w) | (~doe & ~eoe_w & {4{tog}});
  asg_pin_ctrl asg_pin_ctrl_inst (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .CHIP_RESET_N_I(chip_n),
    .LANE_A_POWERDOWN_LOW_I(lane_n[0]), .LANE_B_POWERDOWN_LOW_I(lane_n[1]),
    .PORT_ADDRESS_STRAP_I(5'h0a), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WE_I(we),
    .REG_RE_I(re), .REG_RDATA_O(rdat), .MDC_I(mdc), .MDIO_I(mdio_w), .MDIO_O(mdo),
    .MDIO_OE_O(mdoe), .AUX_CLK_I(pin_w[0]), .AUX_CLK_O(dout[0]), .AUX_CLK_OE_O(doe[0]),
    .AUX_INCOMING_DATA_PIN_I(pin_w[1]), .AUX_INCOMING_DATA_PIN_O(dout[1]),
    .AUX_INCOMING_DATA_PIN_OE_O(doe[1]), .AUX_OUTGOING_DATA_PIN_I(pin_w[2]),
    .AUX_OUTGOING_DATA_PIN_O(dout[2]), .AUX_OUTGOING_DATA_PIN_OE_O(doe[2]),
    .AUX_SELECT_I(pin_w[3]), .AUX_SELECT_O(dout[3]), .AUX_SELECT_OE_O(doe[3])
  );
  asg_spi_partner asg_spi_partner_inst (
    .sclk_i(pin_w[0]), .sel_n_i(pin_w[3]), .mosi_i(pin_w[2]), .tx_i(8'h3c),
    .miso_o(p_o), .miso_oe_o(p_oe), .rx_o(p_rx)
  );
  task automatic conclude();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks++;
    if (got !== ex) begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdat;
  endtask : rd
  task automatic rchk(input string nm, input logic [2:0] a, input logic [15:0] ex);
    rd(a);
    chk(nm, ex, v);
  endtask : rchk
  task automatic pchk(input logic [3:0] oe, input logic [3:0] lv);
    chk("pin oe", {12'h0, oe}, {12'h0, doe});
    chk("pin level", {12'h0, lv}, {12'h0, doe & dout});
  endtask : pchk
  task automatic mslot(input logic b, input logic oe, output logic smp);
    m_o = b;
    m_oe = oe;
    #8 smp = mdio_w;
    mdc = 1'b1;
    #7 mdc = 1'b0;
  endtask : mslot
  task automatic mdio(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
      input logic [15:0] d);
    logic [33:0] fr;
    logic b;
    fr = {4'b1101, op, phy, rg, 2'b10, d};
    repeat (8) mslot(1'b1, 1'b0, b);
    for (int i = 33; i >= 0; i--) begin
      mslot(fr[i], op == `ASG_OP_WR || i > 17, b);
      v = {v[14:0], b};
    end
    mslot(1'b1, 1'b0, b);
    repeat (10) @(posedge clk);
  endtask : mdio
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (8) mslot(1'b1, 1'b0, s);
    pchk(4'hd, 4'h8);
    chk("mdio oe", 16'h0, {15'h0, mdoe});
    repeat (1000) @(posedge clk);
    chip_n <= 1'b1;
    repeat (6) @(posedge clk);
    rchk("aux", 3'h2, 16'h2123);
    pchk(4'hd, 4'h8);
    wr(3'h6, 16'hffff);
    rchk("unmapped", 3'h6, 16'h0);
    for (int c = 1; c < 8; c++) begin
      wr(3'h2, 16'h1111 * 16'(c));
      rchk("aux code", 3'h2, 16'h1111 * 16'(c));
      pchk((c == 2 || c == 3) ? 4'hf : 4'h0, (c == 3) ? 4'hf : 4'h0);
    end
    wr(3'h2, 16'h3212);
    @(posedge clk);
    #1 pchk(4'hb, 4'h1);
    wr(3'h2, 16'h1111);
    eoe <= 4'hf;
    elv <= 4'ha;
    repeat (6) @(posedge clk);
    rd(3'h3);
    chk("pin in", 16'ha, {12'h0, v[3:0]});
    wr(3'h2, 16'h0);
    eoe <= 4'h0;
    wr(3'h4, 16'h00a5);
    v = 16'h8000;
    for (n = 0; n < 200 && v[15]; n++) rd(3'h3);
    if (v[15]) begin
      fail_count++;
      conclude();
    end
    chk("spi tx", 16'h00a5, {8'h0, p_rx});
    rd(3'h4);
    chk("spi rx", 16'h003c, {8'h0, v[7:0]});
    mdio(`ASG_OP_WR, 5'h0a, 5'h0f, 16'h3333);
    rchk("mdio aux", 3'h2, 16'h3333);
    mdio(`ASG_OP_WR, 5'h0c, 5'h0f, 16'h1111);
    rchk("foreign", 3'h2, 16'h3333);
    mdio(`ASG_OP_WR, 5'h0b, 5'h01, 16'h8000);
    rchk("pd b", 3'h1, 16'h8000);
    rchk("pd a", 3'h0, 16'h0);
    wr(3'h0, 16'h8000);
    mdio(`ASG_OP_RD, 5'h0a, 5'h0f, 16'h0);
    chk("rd in pd", 16'h3333, v);
    mdio(`ASG_OP_RD, 5'h0a, 5'h01, 16'h0);
    chk("rd pd a", 16'h8000, v);
    pchk(4'hf, 4'hf);
    @(posedge clk);
    lane_n <= 2'b00;
    repeat (2) @(posedge clk);
    #1 pchk(4'h0, 4'h0);
    mdio(`ASG_OP_RD, 5'h0a, 5'h0f, 16'h0);
    chk("mdio pin pd", 16'hffff, v);
    @(posedge clk);
    lane_n <= 2'b11;
    chip_n <= 1'b0;
    repeat (8) mslot(1'b1, 1'b0, s);
    pchk(4'hd, 4'h8);
    chk("mdio rst", 16'h0, {15'h0, mdoe});
    @(posedge clk);
    chip_n <= 1'b1;
    repeat (6) @(posedge clk);
    rchk("aux rst", 3'h2, 16'h2123);
    rchk("pd a rst", 3'h0, 16'h0);
    rchk("pd b rst", 3'h1, 16'h0);
    conclude();
  end
endmodule : tb_asg_pin_ctrl
